/* File: hdl/reset_cause_defines.vh */
// Register offsets, field positions, reset values and timing counts of the reset cause logic
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH
`define ADDR_POWER_STATUS 5'h00
`define ADDR_CAUSE 5'h04
`define ADDR_IRQ_STATUS 5'h08
`define ADDR_IRQ_CLEAR 5'h0c
`define ADDR_IRQ_ENABLE 5'h10
`define ADDR_CONTROL 5'h14
`define ADDR_KEEP 5'h18
`define ADDR_SCRATCH 5'h1c
`define PS_BROWNOUT_BIT 0
`define PS_POWERON_BIT 1
`define ST_TIMEOUT_BIT 0
`define ST_POWERDOWN_BIT 1
`define CTRL_SLEEP_BIT 0
`define CTRL_KICK_BIT 1
`define CAUSE_POWERON 3'h0
`define CAUSE_PIN_RUN 3'h1
`define CAUSE_PIN_SLEEP 3'h2
`define CAUSE_WDOG_RUN 3'h3
`define CAUSE_WDOG_WAKE 3'h4
`define CAUSE_BROWNOUT 3'h5
`define SCRATCH_RESET 32'h00000000
`define PIN_FILTER_NS 2000
`define CLK_PERIOD_NS 40
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: hdl/reset_pin_filter.v */
// Glitch filter on the low-active external reset pin
`timescale 1ns/1ps
module reset_pin_filter #(
	parameter COUNT = 50
)(
	input wire aclk,
	input wire aresetn,
	input wire pin_n,
	output reg reset_req
);
	reg [15:0] low_count;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			low_count <= 16'h0000;
			reset_req <= 1'b0;
		end
		else if (pin_n)
		begin
			low_count <= 16'h0000;
			reset_req <= 1'b0;
		end
		else if (low_count == COUNT[15:0] - 16'h0001)
		begin
			reset_req <= 1'b1;
		end
		else
		begin
			low_count <= low_count + 16'h0001;
		end
	end
endmodule

/* File: hdl/reset_event_detect.v */
// Rising edge detector for the reset sources
`timescale 1ns/1ps
module reset_event_detect #(
	parameter WIDTH = 4
)(
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] pulse
);
	reg [WIDTH-1:0] last;
	always @(posedge aclk)
	begin
		if (!aresetn)
			last <= {WIDTH{1'b0}};
		else
			last <= level;
	end
	assign pulse = level & ~last;
endmodule

/* File: hdl/reset_cause_status_logic.v */
// Reset cause classification, power status flags and register bus of the reset block
`timescale 1ns/1ps
`include "reset_cause_defines.vh"
module reset_cause_status_logic #(
	parameter FILTER_CYCLES = `PIN_FILTER_CYCLES
)(
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire poweron_detect,
	input wire brownout_detect,
	input wire brownout_detect_enable,
	input wire watchdog_timeout,
	input wire external_reset_pin_in,
	output wire external_reset_pin_out,
	output wire external_reset_pin_oe,
	output reg core_reset,
	output reg core_resume,
	output wire irq
);
	reg brownout_flag;
	reg poweron_flag;
	reg timeout_flag;
	reg powerdown_flag;
	reg sleeping;
	reg [2:0] last_cause;
	reg [31:0] scratch;
	reg [31:0] keep;
	reg [5:0] irq_status;
	reg [5:0] irq_enable;
	reg aw_held;
	reg w_held;
	reg [4:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire pin_reset;
	wire [3:0] src_pulse;
	wire ev_por;
	wire ev_bor;
	wire ev_pin;
	wire ev_wdt;
	reg [5:0] cause_onehot;
	reg [2:0] next_cause;
	reg any_event;
	wire do_write;
	wire [31:0] wmask;
	wire wr_power_status;
	wire wr_control;
	wire wr_scratch;
	wire wr_keep;
	wire wr_irq_enable;
	wire wr_irq_clear;

	function [31:0] strb_mask;
		input [3:0] strb;
		begin
			strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		end
	endfunction

	function is_addr;
		input [4:0] addr;
		input [4:0] reg_addr;
		begin
			is_addr = (addr[4:2] == reg_addr[4:2]);
		end
	endfunction

	reset_pin_filter #(
		.COUNT(FILTER_CYCLES)
	) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_n(external_reset_pin_in),
		.reset_req(pin_reset)
	);

	reset_event_detect #(
		.WIDTH(4)
	) u_events (
		.aclk(aclk),
		.aresetn(aresetn),
		.level({watchdog_timeout, pin_reset, brownout_detect, poweron_detect}),
		.pulse(src_pulse)
	);

	assign ev_por = src_pulse[0];
	assign ev_bor = src_pulse[1] & ~ev_por;
	assign ev_pin = src_pulse[2] & ~ev_por & ~ev_bor;
	assign ev_wdt = src_pulse[3] & ~ev_por & ~ev_bor & ~ev_pin;

	// Watchdog never drives the pin; pad is input only
	assign external_reset_pin_out = 1'b0;
	assign external_reset_pin_oe = 1'b0;

	always @*
	begin
		next_cause = last_cause;
		cause_onehot = 6'h00;
		any_event = 1'b1;
		if (ev_por)
			next_cause = `CAUSE_POWERON;
		else if (ev_bor)
			next_cause = `CAUSE_BROWNOUT;
		else if (ev_pin && sleeping)
			next_cause = `CAUSE_PIN_SLEEP;
		else if (ev_pin)
			next_cause = `CAUSE_PIN_RUN;
		else if (ev_wdt && sleeping)
			next_cause = `CAUSE_WDOG_WAKE;
		else if (ev_wdt)
			next_cause = `CAUSE_WDOG_RUN;
		else
			any_event = 1'b0;
		if (any_event)
			cause_onehot[next_cause] = 1'b1;
	end

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign wmask = strb_mask(w_strb);
	assign irq = |(irq_status & irq_enable);
	// Register write strobes, one per writable register
	assign wr_power_status = do_write & is_addr(aw_addr, `ADDR_POWER_STATUS) & w_strb[0];
	assign wr_control = do_write & is_addr(aw_addr, `ADDR_CONTROL) & w_strb[0];
	assign wr_scratch = do_write & is_addr(aw_addr, `ADDR_SCRATCH);
	assign wr_keep = do_write & is_addr(aw_addr, `ADDR_KEEP);
	assign wr_irq_enable = do_write & is_addr(aw_addr, `ADDR_IRQ_ENABLE) & w_strb[0];
	assign wr_irq_clear = do_write & is_addr(aw_addr, `ADDR_IRQ_CLEAR) & w_strb[0];

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr > `ADDR_SCRATCH) ? 2'b10 : 2'b00;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			brownout_flag <= 1'b1;
			poweron_flag <= 1'b0;
			timeout_flag <= 1'b1;
			powerdown_flag <= 1'b1;
			sleeping <= 1'b0;
			last_cause <= `CAUSE_POWERON;
			scratch <= `SCRATCH_RESET;
			core_reset <= 1'b0;
			core_resume <= 1'b0;
		end
		else
		begin
			core_reset <= 1'b0;
			core_resume <= 1'b0;
			if (wr_power_status)
			begin
				brownout_flag <= w_data[`PS_BROWNOUT_BIT];
				poweron_flag <= w_data[`PS_POWERON_BIT];
			end
			if (wr_control)
			begin
				sleeping <= w_data[`CTRL_SLEEP_BIT];
				if (w_data[`CTRL_SLEEP_BIT])
				begin
					timeout_flag <= 1'b1;
					powerdown_flag <= 1'b0;
				end
				if (w_data[`CTRL_KICK_BIT])
				begin
					timeout_flag <= 1'b1;
					powerdown_flag <= 1'b1;
				end
			end
			if (wr_scratch)
				scratch <= (scratch & ~wmask) | (w_data & wmask);
			// Hardware reset events below win over any software write above
			if (any_event)
				last_cause <= next_cause;
			if (ev_por)
			begin
				poweron_flag <= 1'b0;
				brownout_flag <= brownout_detect_enable ? 1'b1 : brownout_flag;
				timeout_flag <= 1'b1;
				powerdown_flag <= 1'b1;
				sleeping <= 1'b0;
				scratch <= `SCRATCH_RESET;
				core_reset <= 1'b1;
			end
			else if (ev_bor)
			begin
				brownout_flag <= 1'b0;
				timeout_flag <= 1'b1;
				powerdown_flag <= 1'b1;
				sleeping <= 1'b0;
				scratch <= `SCRATCH_RESET;
				core_reset <= 1'b1;
			end
			else if (ev_pin)
			begin
				if (sleeping)
				begin
					timeout_flag <= 1'b1;
					powerdown_flag <= 1'b0;
				end
				sleeping <= 1'b0;
				scratch <= `SCRATCH_RESET;
				core_reset <= 1'b1;
			end
			else if (ev_wdt)
			begin
				timeout_flag <= 1'b0;
				powerdown_flag <= ~sleeping;
				sleeping <= 1'b0;
				if (sleeping)
					core_resume <= 1'b1;
				else
				begin
					scratch <= `SCRATCH_RESET;
					core_reset <= 1'b1;
				end
			end
		end
	end

	// Interrupt status: a new event wins over a clear in the same cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_status <= 6'h00;
			irq_enable <= 6'h00;
		end
		else
		begin
			if (wr_irq_enable)
				irq_enable <= w_data[5:0];
			if (wr_irq_clear)
				irq_status <= (irq_status & ~w_data[5:0]) | cause_onehot;
			else
				irq_status <= irq_status | cause_onehot;
		end
	end

	// Keep register has no reset at all; only software writes it
	always @(posedge aclk)
	begin
		if (wr_keep)
			keep <= (keep & ~wmask) | (w_data & wmask);
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else if (s_axi_arvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h00000000;
			case (s_axi_araddr[4:2])
				3'h0: s_axi_rdata <= {30'h00000000, poweron_flag, brownout_flag};
				3'h1: s_axi_rdata <= {27'h0000000, powerdown_flag, timeout_flag, last_cause};
				3'h2: s_axi_rdata <= {26'h0000000, irq_status};
				3'h3: s_axi_rdata <= 32'h00000000;
				3'h4: s_axi_rdata <= {26'h0000000, irq_enable};
				3'h5: s_axi_rdata <= {31'h00000000, sleeping};
				3'h6: s_axi_rdata <= keep;
				3'h7: s_axi_rdata <= scratch;
				default: s_axi_rresp <= 2'b10;
			endcase
		end
	end
endmodule

/* File: testbench/reset_cause_monitor.sv */
// Port assertions of the reset cause block
`timescale 1ns/1ps
module reset_cause_monitor #(
	parameter FILTER_CYCLES = 50
)(
	input wire aclk,
	input wire aresetn,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire poweron_detect,
	input wire brownout_detect,
	input wire watchdog_timeout,
	input wire external_reset_pin_in,
	input wire external_reset_pin_out,
	input wire external_reset_pin_oe,
	input wire core_reset,
	input wire core_resume
);
	wire src = poweron_detect | brownout_detect | watchdog_timeout;
	reg [7:0] low_run;
	// Cycles the pin has been low in a row
	always @(posedge aclk)
		if (!aresetn || external_reset_pin_in)
			low_run <= 8'h00;
		else if (low_run != 8'hff)
			low_run <= low_run + 8'h01;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_PIN_UNDRIVEN: assert property (!external_reset_pin_oe && !external_reset_pin_out)
		else $error("reset pin driven");
	AST_POR_RESETS: assert property ($rose(poweron_detect) |-> ##[1:2] core_reset)
		else $error("power-on gave no core reset");
	AST_BOR_RESETS: assert property ($rose(brownout_detect) |-> ##[1:2] core_reset)
		else $error("brown-out gave no core reset");
	AST_WDOG_ACTS: assert property ($rose(watchdog_timeout) |-> ##[1:2] (core_reset || core_resume))
		else $error("watchdog event lost");
	AST_SHORT_PULSE: assert property (core_reset |->
		$past(src) || $past(src, 2) || $past(src, 3) || low_run >= FILTER_CYCLES - 1)
		else $error("core reset without a cause");
	AST_WAKE_ALONE: assert property (core_resume |-> !core_reset)
		else $error("wake-up also reset the core");
	AST_PULSE_ONE: assert property (core_reset |=> !core_reset)
		else $error("core reset longer than one cycle");
	AST_BRESP_OK: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
		else $error("write response not okay");
	cover property (core_resume);
	cover property (core_reset && low_run != 8'h00);
	cover property ($rose(external_reset_pin_in) && low_run < FILTER_CYCLES - 1);
endmodule
bind reset_cause_status_logic reset_cause_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) mon (.aclk,
	.aresetn, .s_axi_bresp, .s_axi_bvalid, .poweron_detect, .brownout_detect, .watchdog_timeout,
	.external_reset_pin_in, .external_reset_pin_out, .external_reset_pin_oe, .core_reset,
	.core_resume);

/* File: testbench/reset_sources.sv */
// Model of the supply detectors, the watchdog and the pulled-up reset pin
`timescale 1ns/1ps
module reset_sources (
	input wire aclk,
	output logic poweron_detect = 0,
	output logic brownout_detect = 0,
	output logic watchdog_timeout = 0,
	output logic external_reset_pin_in = 1,
	output logic brownout_detect_enable = 1
);
	// Hold one source active for n cycles; the pin then returns to its pull-up level
	task fire(input int s, input int n);
		begin
			@(posedge aclk);
			case (s)
				0: poweron_detect <= 1;
				1: brownout_detect <= 1;
				2: watchdog_timeout <= 1;
				default: external_reset_pin_in <= 0;
			endcase
			repeat (n) @(posedge aclk);
			poweron_detect <= 0;
			brownout_detect <= 0;
			watchdog_timeout <= 0;
			external_reset_pin_in <= 1;
			repeat (4) @(posedge aclk);
		end
	endtask
	// Change the brown-out detection configuration level
	task set_enable(input logic v);
		begin
			@(posedge aclk);
			brownout_detect_enable <= v;
		end
	endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking testbench of the reset cause block
`timescale 1ns/1ps
module tb;
	logic aclk = 0;
	logic aresetn = 0;
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire awready, wready, bvalid, arready, rvalid, irq, pin_oe;
	wire [31:0] rdata;
	wire [1:0] rresp;
	wire poweron_detect, brownout_detect, watchdog_timeout;
	wire external_reset_pin_in, brownout_detect_enable;
	int n_fail = 0;
	int n_tests = 0;
	always #20 aclk = ~aclk;
	reset_sources src_m (.aclk, .poweron_detect, .brownout_detect, .watchdog_timeout,
		.external_reset_pin_in, .brownout_detect_enable);
	reset_cause_status_logic #(.FILTER_CYCLES(4)) dut (.aclk, .aresetn,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .poweron_detect, .brownout_detect,
		.watchdog_timeout, .external_reset_pin_in, .brownout_detect_enable,
		.external_reset_pin_out(), .external_reset_pin_oe(pin_oe), .core_reset(),
		.core_resume(), .irq);
	task wr(input logic [4:0] a, input logic [31:0] d);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
			forever
			begin
				@(posedge aclk);
				if (awready) awvalid <= 0;
				if (wready) wvalid <= 0;
				if (bvalid) break;
			end
			bready <= 0;
		end
	endtask
	task chk_reg(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] rr;
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
			d = 'x;
			rr = 'x;
			forever
			begin
				@(posedge aclk);
				if (arready) arvalid <= 0;
				if (rvalid)
				begin
					d = rdata;
					rr = rresp;
					break;
				end
			end
			rready <= 0;
			n_tests++;
			if (d !== e || rr !== 2'b00)
			begin
				n_fail++;
				$display("ERROR %0t read %h got %h resp %b exp %h", $time, a, d, rr, e);
			end
		end
	endtask
	task chk_bit(input logic g, input logic e);
		begin
			#1;
			n_tests++;
			if (g !== e)
			begin
				n_fail++;
				$display("ERROR %0t port got %b exp %b", $time, g, e);
			end
		end
	endtask
	task final_report;
		begin
			$display("tests %0d failures %0d", n_tests, n_fail);
			if (n_fail == 0 && n_tests > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task t_por;
		begin
			src_m.fire(0, 3);
			chk_reg(5'h00, 32'h1);
			chk_reg(5'h04, 32'h18);
			wr(5'h00, 32'h3);
			$display("power-on test done");
		end
	endtask
	task t_bor;
		begin
			wr(5'h18, 32'hc3c3a5a5);
			wr(5'h1c, 32'h12345678);
			src_m.fire(1, 3);
			chk_reg(5'h00, 32'h2);
			chk_reg(5'h04, 32'h1d);
			chk_reg(5'h1c, 32'h0);
			chk_reg(5'h18, 32'hc3c3a5a5);
			wr(5'h00, 32'h3);
			$display("brown-out test done");
		end
	endtask
	task t_pin;
		begin
			src_m.fire(3, 2);
			chk_reg(5'h04, 32'h1d);
			src_m.fire(3, 10);
			chk_reg(5'h04, 32'h19);
			chk_reg(5'h00, 32'h3);
			wr(5'h1c, 32'h11);
			wr(5'h14, 32'h1);
			src_m.fire(3, 10);
			chk_reg(5'h04, 32'h0a);
			chk_reg(5'h1c, 32'h0);
			$display("pin test done");
		end
	endtask
	task t_wdog;
		begin
			wr(5'h14, 32'h0);
			src_m.fire(2, 3);
			chk_reg(5'h04, 32'h13);
			chk_bit(pin_oe, 0);
			wr(5'h1c, 32'h77);
			wr(5'h14, 32'h1);
			src_m.fire(2, 3);
			chk_reg(5'h04, 32'h04);
			chk_reg(5'h1c, 32'h77);
			chk_reg(5'h18, 32'hc3c3a5a5);
			wr(5'h14, 32'h0);
			$display("watchdog test done");
		end
	endtask
	task t_irq;
		begin
			chk_reg(5'h08, 32'h3f);
			wr(5'h10, 32'h20);
			chk_bit(irq, 1);
			wr(5'h10, 32'h0);
			chk_bit(irq, 0);
			wr(5'h10, 32'h20);
			wr(5'h0c, 32'h20);
			chk_bit(irq, 0);
			chk_reg(5'h08, 32'h1f);
			chk_reg(5'h0c, 32'h0);
			$display("interrupt test done");
		end
	endtask
	task t_bor_off;
		begin
			wr(5'h00, 32'h2);
			src_m.set_enable(0);
			src_m.fire(0, 3);
			chk_reg(5'h00, 32'h0);
			chk_reg(5'h04, 32'h18);
			src_m.set_enable(1);
			$display("brown-out disabled test done");
		end
	endtask
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		t_por();
		t_bor();
		t_pin();
		t_wdog();
		t_irq();
		t_bor_off();
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		final_report();
	end
endmodule
